/* File: core/opamp_pkg.sv */
/*
 * Constants for the amplifier/comparator control block: register offset,
 * control field positions, reset value and the analog stage mode type.
 * Assumes a Wishbone slave with 32-bit data and byte addressing.
 */
package opamp_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	// Printed offset is not a multiple of four, so it is an index
	localparam logic [7:0] ctrl_index = 8'h1f;
	localparam logic [9:0] ctrl_byte_addr = {ctrl_index, 2'h0};

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int trim_lsb = 0;
	localparam int trim_msb = 3;
	localparam int ref_sel_bit = 4;
	localparam int mode_bit = 5;
	localparam int output_bit = 6;
	localparam int enable_bit = 7;
	localparam logic [7:0] ctrl_reset = 8'h00;
	localparam logic [7:0] ctrl_write_mask = 8'hbf;

	// ------------------------------------------------------------
	// Build-time stage behaviour
	// ------------------------------------------------------------
	typedef enum logic {stage_comparator, stage_amplifier} stage_kind_type;

endpackage : opamp_pkg

/* File: core/opamp_ctrl_reg.sv */
/*
 * Holds the 8-bit control register and merges the live output status.
 * Assumes write strobes come from the bus slave in the clock domain.
 */
module opamp_ctrl_reg (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_enable,
	// Write port
	input wire logic i_write,
	input wire logic [7:0] i_wdata,
	// Status in
	input wire logic i_status,
	// Register out
	output logic [7:0] o_value
);

	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;

	// ------------------------------------------------------------
	// Next value
	// ------------------------------------------------------------
	// Status bit is never stored from a write
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (i_write) begin
			ctrl_nxt = i_wdata & opamp_pkg::ctrl_write_mask;
		end
	end

	// Register
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_r <= opamp_pkg::ctrl_reset;
		end else if (i_enable) begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// Read view with status merged in
	always_comb begin
		o_value = ctrl_r;
		o_value[opamp_pkg::output_bit] = i_status;
	end

endmodule : opamp_ctrl_reg

/* File: core/opamp_sync.sv */
/*
 * Two-stage synchroniser for the analog stage output.
 * Assumes the comparator output is asynchronous to the clock.
 */
module opamp_sync (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_enable,
	// Level in and out
	input wire logic i_level,
	output logic o_level
);

	logic meta_r;
	logic sync_r;

	// Two flops; first is read only by the second
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else if (i_enable) begin
			meta_r <= i_level;
			sync_r <= meta_r;
		end
	end

	assign o_level = sync_r;

endmodule : opamp_sync

/* File: core/opamp_comparator_control.sv */
/*
 * Control of an on-chip amplifier/comparator: Wishbone slave with one
 * control register, analog switch and trim drive, output status.
 * Assumes classic Wishbone single cycles and an analog stage outside.
 */
// How it works
// - Build option picks amplifier or comparator, comparator default
// - Bit 5 set closes input short switch
// - Bit 4 picks positive or negative reference input while bit 5 is set
// - Bits 0-3 drive offset trim code
// - Bit 6 reads analog output, high reads one
// - Bit 7 enables stage; off floats output
module opamp_comparator_control #(
	parameter opamp_pkg::stage_kind_type stage_kind = opamp_pkg::stage_comparator
) (
	// Clock, reset and freeze
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_clock_enable,
	// Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [9:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Analog stage
	input wire logic i_analog_stage_output,
	output logic o_analog_stage_enable,
	output logic o_amplifier_select,
	output logic o_input_short_switch,
	output logic o_ref_positive_switch,
	output logic o_ref_negative_switch,
	output logic [3:0] o_offset_trim_code,
	// Output pin drive (enable active low)
	output logic o_stage_pin_oe_n
);

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic ack_r;
	logic ack_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic hit;
	logic ctrl_write;
	logic [7:0] ctrl_value;
	logic status_sync;

	assign hit = (i_wb_adr == opamp_pkg::ctrl_byte_addr);
	// Write takes effect on the ack edge, low byte lane only
	assign ctrl_write = i_wb_cyc && i_wb_stb && i_wb_we && ack_r && hit && i_wb_sel[0];

	// Ack one cycle after request, dropped the following cycle
	always_comb begin
		ack_nxt = i_wb_cyc && i_wb_stb && !ack_r;
		rdata_nxt = rdata_r;
		if (ack_nxt) begin
			rdata_nxt = hit ? {24'h000000, ctrl_value} : 32'h00000000;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h00000000;
		end else if (i_clock_enable) begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign o_wb_ack = ack_r;
	assign o_wb_dat = rdata_r;

	// ------------------------------------------------------------
	// Control register and output status
	// ------------------------------------------------------------
	opamp_sync u_sync (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_enable(i_clock_enable),
		.i_level(i_analog_stage_output),
		.o_level(status_sync)
	);

	opamp_ctrl_reg u_ctrl (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_enable(i_clock_enable),
		.i_write(ctrl_write),
		.i_wdata(i_wb_dat[7:0]),
		.i_status(status_sync),
		.o_value(ctrl_value)
	);

	// ------------------------------------------------------------
	// Analog drive
	// ------------------------------------------------------------
	logic en_r, en_nxt;
	logic amp_r, amp_nxt;
	logic short_r, short_nxt;
	logic refp_r, refp_nxt;
	logic refn_r, refn_nxt;
	logic oe_n_r, oe_n_nxt;
	logic [3:0] trim_r, trim_nxt;

	// Decode control fields into switch and trim drive
	always_comb begin
		en_nxt = ctrl_value[opamp_pkg::enable_bit];
		oe_n_nxt = !ctrl_value[opamp_pkg::enable_bit];
		amp_nxt = (stage_kind == opamp_pkg::stage_amplifier);
		short_nxt = ctrl_value[opamp_pkg::mode_bit];
		refp_nxt = ctrl_value[opamp_pkg::mode_bit] && ctrl_value[opamp_pkg::ref_sel_bit];
		refn_nxt = ctrl_value[opamp_pkg::mode_bit] && !ctrl_value[opamp_pkg::ref_sel_bit];
		trim_nxt = ctrl_value[opamp_pkg::trim_msb:opamp_pkg::trim_lsb];
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			en_r <= 1'b0;
			oe_n_r <= 1'b1;
			amp_r <= 1'b0;
			short_r <= 1'b0;
			refp_r <= 1'b0;
			refn_r <= 1'b0;
			trim_r <= 4'h0;
		end else if (i_clock_enable) begin
			en_r <= en_nxt;
			oe_n_r <= oe_n_nxt;
			amp_r <= amp_nxt;
			short_r <= short_nxt;
			refp_r <= refp_nxt;
			refn_r <= refn_nxt;
			trim_r <= trim_nxt;
		end
	end

	assign o_analog_stage_enable = en_r;
	assign o_stage_pin_oe_n = oe_n_r;
	assign o_amplifier_select = amp_r;
	assign o_input_short_switch = short_r;
	assign o_ref_positive_switch = refp_r;
	assign o_ref_negative_switch = refn_r;
	assign o_offset_trim_code = trim_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// A landed write carrying a given data word
	sequence s_ctrl_write(bit [31:0] d);
		ctrl_write && i_clock_enable && (i_wb_dat == d);
	endsequence

	// A landed write, then one more enabled edge for the drive flops
	sequence s_write_settled;
		(ctrl_write && i_clock_enable) ##1 i_clock_enable;
	endsequence

	// A request taken by the slave at this edge
	sequence s_request_taken;
		i_clock_enable && i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence

	// Two enabled edges in a row through the status synchroniser
	sequence s_two_enabled;
		i_clock_enable ##1 i_clock_enable;
	endsequence

	// Short switch follows the written mode bit
	property p_mode_short;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_write_settled |=> o_input_short_switch == $past(i_wb_dat[opamp_pkg::mode_bit], 2);
	endproperty
	a_mode_short: assert property (p_mode_short) else $error("short switch wrong");

	// Reference switches never both closed, closed only in cancel mode
	property p_ref_switch;
		@(posedge i_clock) disable iff (!i_reset_n)
		!(o_ref_positive_switch && o_ref_negative_switch) &&
			((o_ref_positive_switch || o_ref_negative_switch) == o_input_short_switch);
	endproperty
	a_ref_switch: assert property (p_ref_switch) else $error("reference switch wrong");

	// Positive reference switch closes for a set selector in cancel mode
	property p_ref_positive;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_write_settled |=> o_ref_positive_switch ==
			($past(i_wb_dat[opamp_pkg::mode_bit], 2) &&
			$past(i_wb_dat[opamp_pkg::ref_sel_bit], 2));
	endproperty
	a_ref_positive: assert property (p_ref_positive) else $error("positive reference wrong");

	// Negative reference switch closes for a clear selector in cancel mode
	property p_ref_negative;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_write_settled |=> o_ref_negative_switch ==
			($past(i_wb_dat[opamp_pkg::mode_bit], 2) &&
			!$past(i_wb_dat[opamp_pkg::ref_sel_bit], 2));
	endproperty
	a_ref_negative: assert property (p_ref_negative) else $error("negative reference wrong");

	// Trim drive follows the written low nibble
	property p_trim;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_write_settled |=>
			o_offset_trim_code == $past(i_wb_dat[opamp_pkg::trim_msb:opamp_pkg::trim_lsb], 2);
	endproperty
	a_trim: assert property (p_trim) else $error("trim code wrong");

	// Read data carries the synchronised output level
	property p_status;
		@(posedge i_clock) disable iff (!i_reset_n)
		(i_clock_enable && ack_nxt && hit) |=> o_wb_dat[6] == $past(status_sync);
	endproperty
	a_status: assert property (p_status) else $error("status bit wrong");

	// Synchroniser delivers the pin level after two enabled edges
	property p_status_sync;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_two_enabled |=> status_sync == $past(i_analog_stage_output, 2);
	endproperty
	a_status_sync: assert property (p_status_sync) else $error("status sync wrong");

	// Pin drive enable is the inverse of the stage enable
	property p_enable;
		@(posedge i_clock) disable iff (!i_reset_n)
		o_analog_stage_enable == !o_stage_pin_oe_n;
	endproperty
	a_enable: assert property (p_enable) else $error("enable and pin drive disagree");

	// Stage enable and pin drive follow the written enable bit
	property p_enable_write;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_write_settled |=> (o_analog_stage_enable == $past(i_wb_dat[opamp_pkg::enable_bit], 2)) &&
			(o_stage_pin_oe_n == !$past(i_wb_dat[opamp_pkg::enable_bit], 2));
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable drive wrong");

	// Stage kind output matches the build option
	property p_kind;
		@(posedge i_clock) disable iff (!i_reset_n)
		i_clock_enable |=> o_amplifier_select == (stage_kind == opamp_pkg::stage_amplifier);
	endproperty
	a_kind: assert property (p_kind) else $error("stage kind wrong");

	// An all-ones write leaves the status bit unstored
	property p_readonly;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_ctrl_write(32'h000000ff) |=> !u_ctrl.ctrl_r[opamp_pkg::output_bit];
	endproperty
	a_readonly: assert property (p_readonly) else $error("status bit stored");

	// Any landed write stores every bit but the status
	property p_write_lands;
		@(posedge i_clock) disable iff (!i_reset_n)
		(ctrl_write && i_clock_enable) |=>
			u_ctrl.ctrl_r == ($past(i_wb_dat[7:0]) & opamp_pkg::ctrl_write_mask);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write not stored");

	// A write without byte lane zero leaves the register alone
	property p_lane_ignored;
		@(posedge i_clock) disable iff (!i_reset_n)
		(i_clock_enable && i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && !i_wb_sel[0])
			|=> $stable(u_ctrl.ctrl_r);
	endproperty
	a_lane_ignored: assert property (p_lane_ignored) else $error("lane zero off but stored");

	// Unmapped reads answer zero
	property p_unmapped_read;
		@(posedge i_clock) disable iff (!i_reset_n)
		(i_clock_enable && ack_nxt && !hit) |=> o_wb_dat == 32'h00000000;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

	// Unmapped writes leave the register alone
	property p_unmapped_write;
		@(posedge i_clock) disable iff (!i_reset_n)
		(i_clock_enable && i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && !hit)
			|=> $stable(u_ctrl.ctrl_r);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write stored");

	// Ack one cycle after a request is taken
	property p_ack_answer;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_request_taken |=> o_wb_ack;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("ack missing");

	// No ack without a request
	property p_ack_idle;
		@(posedge i_clock) disable iff (!i_reset_n)
		(i_clock_enable && !(i_wb_cyc && i_wb_stb)) |=> !o_wb_ack;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

	// Ack lasts one enabled cycle
	property p_ack_pulse;
		@(posedge i_clock) disable iff (!i_reset_n)
		(o_wb_ack && i_clock_enable) |=> !o_wb_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

	// Low clock enable freezes bus and drive outputs
	property p_freeze;
		@(posedge i_clock) disable iff (!i_reset_n)
		!i_clock_enable |=> $stable(o_wb_ack) && $stable(o_wb_dat) && $stable(o_offset_trim_code)
			&& $stable(o_analog_stage_enable) && $stable(o_input_short_switch);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

endmodule : opamp_comparator_control

/* File: tb/analog_stage_model.sv */
/*
 * Behavioural analog stage: a comparator whose trip point is the trim code.
 * Assumes the control block drives enable, short switch and trim directly.
 */
module analog_stage_model #(
	parameter logic [3:0] trip_code = 4'h9
) (
	// Control from the block
	input wire logic i_clock,
	input wire logic i_enable,
	input wire logic i_short,
	input wire logic [3:0] i_trim,
	// Signal level at the pins
	input wire logic i_level,
	// Stage output
	output logic o_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drive;
	logic last_r = 1'b0;
	initial o_out = 1'b0;
	// Shorted inputs trip on the trim code, otherwise the pin level decides
	assign drive = i_short ? (i_trim >= trip_code) : i_level;
	// Disabled stage floats: shows the inverse of its last driven level
	always @(posedge i_clock) begin
		if (!i_enable) begin
			o_out <= ~last_r;
		end else begin
			o_out <= drive;
			last_r <= drive;
		end
	end
endmodule : analog_stage_model

/* File: tb/testbench.sv */
/*
 * Self-checking bench: Wishbone master tasks, one task per scenario.
 * Assumes the analog stage model trips at trim code 9.
 */
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0, i_reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [3:0] sel = 4'h0, trim;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic ack, stage_out, en, amp_sel, short_sw, ref_p, ref_n, oe_n, level = 1'b0;
	logic ce = 1'b1, amp_sel_b;
	int checks = 0, n_mismatch = 0, cycles = 0, first;
	// ----------------------------------------
	// Design, analog partner and clock
	// ----------------------------------------
	opamp_comparator_control opamp_comparator_control_inst (.i_clock(i_clock),
		.i_reset_n(i_reset_n), .i_clock_enable(ce), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_analog_stage_output(stage_out), .o_analog_stage_enable(en),
		.o_amplifier_select(amp_sel), .o_input_short_switch(short_sw),
		.o_ref_positive_switch(ref_p), .o_ref_negative_switch(ref_n),
		.o_offset_trim_code(trim), .o_stage_pin_oe_n(oe_n));
	analog_stage_model analog_stage_model_inst (.i_clock(i_clock), .i_enable(en),
		.i_short(short_sw), .i_trim(trim), .i_level(level), .o_out(stage_out));
	// Amplifier build, looked at only for its stage kind
	opamp_comparator_control #(.stage_kind(opamp_pkg::stage_amplifier))
		opamp_comparator_control_amp_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_clock_enable(ce), .i_wb_cyc(1'b0), .i_wb_stb(1'b0), .i_wb_we(1'b0),
		.i_wb_adr(10'h000), .i_wb_sel(4'h0), .i_wb_dat(32'h00000000), .o_wb_dat(),
		.o_wb_ack(), .i_analog_stage_output(1'b0), .o_analog_stage_enable(),
		.o_amplifier_select(amp_sel_b), .o_input_short_switch(), .o_ref_positive_switch(),
		.o_ref_negative_switch(), .o_offset_trim_code(), .o_stage_pin_oe_n());
	initial begin
		forever #5 i_clock = ~i_clock;
	end
	// Hang guard
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test
	// Classic single cycle, held until ack, then a settle gap
	task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d,
		input logic [3:0] s);
		@(posedge i_clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= {24'h0, d};
		@(posedge i_clock);
		while (ack !== 1'b1) @(posedge i_clock);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		repeat (6) @(posedge i_clock);
	endtask : wb
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		`CHK({oe_n, en, amp_sel, short_sw, trim}, 8'h80)
		repeat (4) @(posedge i_clock);
		wb(1'b0, 10'h07c, 8'h00, 4'h1);
		`CHK(q, 32'h00000040)
		`CHK(amp_sel_b, 1'b1)
	endtask : t_reset
	task automatic t_fields();
		wb(1'b1, 10'h07c, 8'hff, 4'h1);
		`CHK({en, oe_n, short_sw, ref_p, ref_n, trim}, 9'h16f)
		wb(1'b1, 10'h07c, 8'ha5, 4'h1);
		`CHK({ref_p, ref_n, trim}, 6'h15)
		wb(1'b1, 10'h07c, 8'h00, 4'h0); // sel lane 0 off, ignored
		wb(1'b1, 10'h3fc, 8'h00, 4'h1); // unmapped write, ignored
		wb(1'b0, 10'h07c, 8'h00, 4'h1);
		`CHK(q, 32'h000000a5)
		wb(1'b0, 10'h3fc, 8'h00, 4'h1);
		`CHK(q, 32'h0)
	endtask : t_fields
	task automatic t_calibrate();
		first = -1;
		wb(1'b1, 10'h07c, 8'ha0, 4'h1);
		for (int t = 0; t < 16 && first < 0; t++) begin
			wb(1'b1, 10'h07c, 8'hb0 | 8'(t), 4'h1);
			wb(1'b0, 10'h07c, 8'h00, 4'h1);
			if (q[6] === 1'b1) first = t;
		end
		`CHK(first, 9)
		wb(1'b1, 10'h07c, 8'h89, 4'h1);
		`CHK({short_sw, ref_p, ref_n}, 3'h0)
	endtask : t_calibrate
	task automatic t_normal();
		level <= 1'b0;
		wb(1'b1, 10'h07c, 8'hc0, 4'h1);
		wb(1'b0, 10'h07c, 8'h00, 4'h1);
		`CHK(q[7:0], 8'h80)
		level <= 1'b1;
		repeat (4) @(posedge i_clock);
		wb(1'b0, 10'h07c, 8'h00, 4'h1);
		`CHK(q[7:0], 8'hc0)
		wb(1'b1, 10'h07c, 8'h00, 4'h1);
		`CHK({en, oe_n}, 2'h1)
	endtask : t_normal
	// Request held while the clock enable is low, then let through
	task automatic t_freeze();
		wb(1'b1, 10'h07c, 8'h8f, 4'h1);
		@(posedge i_clock);
		ce <= 1'b0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= 1'b1;
		adr <= 10'h07c;
		sel <= 4'h1;
		wdat <= 32'h00000000;
		repeat (4) @(posedge i_clock);
		`CHK({ack, en, trim}, 6'h1f)
		ce <= 1'b1;
		while (ack !== 1'b1) @(posedge i_clock);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		repeat (6) @(posedge i_clock);
		`CHK({ack, en, oe_n, trim}, 7'h10)
	endtask : t_freeze
	// Main sequence
	initial begin
		repeat (5) @(posedge i_clock);
		i_reset_n <= 1'b1;
		t_reset();
		t_fields();
		t_calibrate();
		t_normal();
		t_freeze();
		end_of_test();
	end
endmodule : testbench
